// file: hdl/pictr_lin11_norm.sv
// Purpose: Converts a linear-11 value to a signed fixed-point count at a target exponent
// Assumes: Target exponent is a parameter; result is truncated to 24 bits, lost flags left-shift overflow
// Notes: Rounds to nearest when shifting right
`timescale 1ns/1ps
`default_nettype none
module pictr_lin11_norm
    import pictr_pkg::*;
#(
    parameter int TARGET_EXP = -6
) (
    input wire pictr_lin11_s value,
    output logic signed [23:0] scaled,
    output logic lost
);
    logic signed [5:0] exp_s;
    logic signed [6:0] shift;
    logic signed [23:0] man_ext;
    logic signed [47:0] wide;
    assign exp_s = {value.exponent[4], value.exponent};
    assign shift = 7'(exp_s) - 7'(TARGET_EXP);
    assign man_ext = 24'(signed'(value.mantissa));
    always_comb begin
        wide = 48'(man_ext);
        lost = 1'b0;
        if (shift >= 0) begin
            wide = 48'(man_ext) <<< shift;
            lost = (wide > 48'sh7FFFFF) || (wide < -48'sh800000);
        end else begin
            wide = (48'(man_ext) + (48'sh1 <<< (-shift - 1))) >>> (-shift);
        end
        scaled = wide[23:0];
    end
endmodule
`default_nettype wire

// file: hdl/pictr_pkg.sv
// Purpose: Shared constants and types for the phase position and current trim registers
// Assumes: Command codes are byte addresses on the management command port
// Notes: Linear-11 values are exponent in 15:11, mantissa in 10:0
package pictr_pkg;
    localparam logic [7:0] PICTR_CMD_PHASE_POS = 8'h37;
    localparam logic [7:0] PICTR_CMD_GAIN_TRIM = 8'h38;
    localparam logic [7:0] PICTR_CMD_OFFS_TRIM = 8'h39;
    localparam logic [7:0] PICTR_PHASE_ALL = 8'hFF;
    localparam logic [7:0] PICTR_PHASE_LAST = 8'h03;
    localparam int PICTR_EXP_LSB = 11;
    localparam int PICTR_GRPID_LSB = 8;
    localparam int PICTR_GSIZE_LSB = 4;
    localparam logic [3:0] PICTR_GSIZE_MIN = 4'h1;
    localparam logic [3:0] PICTR_GSIZE_MAX = 4'h4;
    // Gain of one in units of 1/64 (exponent -6)
    localparam logic [4:0] PICTR_GAIN_EXP_RST = 5'h1A;
    localparam logic [10:0] PICTR_GAIN_MAN_ONE = 11'h040;
    localparam logic [10:0] PICTR_GAIN_MAN_CAP = 11'h07F;
    localparam logic [4:0] PICTR_OFFS_EXP_RST = 5'h1C;
    localparam logic [15:0] PICTR_PHASE_RST = 16'h0010;
    localparam int PICTR_PHASE_DEG_FULL = 360;
    localparam int PICTR_CLK_HZ = 20000000;

    typedef struct packed {
        logic [3:0] unused;
        logic [3:0] group_identifier;
        logic [3:0] group_size;
        logic [3:0] position_index;
    } pictr_phase_s;

    typedef struct packed {
        logic [4:0] exponent;
        logic [10:0] mantissa;
    } pictr_lin11_s;
endpackage

// file: hdl/pictr_regs.sv
// Purpose: Phase position, current gain trim and per-phase offset trim commands
// Assumes: Command port is a decoded word interface from the serial bus engine
// Notes: Gain and offset are held normalised; reads return linear-11 words
//
// Overview of operation
// - Phase position accepts word writes only standalone; read back as a word.
// - Phase position bits 15 to 12 are read-only and read as zero.
// - Bits 11 to 8 hold group identifier, any value zero to fifteen.
// - Bits 7 to 4 hold group size, valid one through four.
// - Bits 3 to 0 hold position index, below group size.
// - Oscillator delay is 360 over group size times position index.
// - In a multi-phase stack the phase position command refuses writes.
// - Writability comes from stack setting sampled at power-on only.
// - Sensed current is multiplied by gain trim before report; default one.
// - Trims use signed linear-11: exponent 15:11, mantissa 10:0.
// - Out-of-range trim writes are invalid, set status and alert host.
// - After restore, gain rounds to nearest 1/64, capped at 1.984.
// - Each phase holds its own offset; stack offset is their sum.
// - After restore, offset loads supported value matching last store.
// - Runtime offset writes keep full resolution within supported limits; the code rounds them to 1/16.
// - Phase selector 0 to 3 addresses that one phase's offset only.
// - Selector all splits writes evenly; reads give phase zero times count.
`timescale 1ns/1ps
`default_nettype none
module pictr_regs
    import pictr_pkg::*;
#(
    parameter int NUM_PHASES = 4,
    parameter int CLK_HZ = PICTR_CLK_HZ,
    parameter logic signed [23:0] OFFS_MIN = -24'sd1024,
    parameter logic signed [23:0] OFFS_MAX = 24'sd1023
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [7:0] phase_sel,
    input wire logic stack_config_multi,
    input wire logic nvm_restore,
    input wire pictr_lin11_s nvm_gain,
    input wire pictr_lin11_s nvm_offset,
    input wire pictr_phase_s nvm_phase_pos,
    input wire logic signed [15:0] sensed_current,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    output logic invalid_data,
    output logic refused_write,
    output logic [8:0] phase_delay_deg,
    output logic [3:0] group_identifier,
    output logic signed [23:0] reported_current,
    output logic signed [23:0] stack_offset
);
    localparam int NPW = $clog2(NUM_PHASES + 1);
    localparam logic [NPW-1:0] NPH = NPW'(NUM_PHASES);

    typedef enum logic [1:0] {
        PICTR_ST_BOOT = 2'b00,
        PICTR_ST_SAMPLE = 2'b01,
        PICTR_ST_RUN = 2'b11
    } pictr_state_e;

    pictr_state_e state_q, state_d;
    logic stack_locked_q;
    pictr_phase_s phase_q;
    logic signed [23:0] gain_q;
    logic signed [23:0] offs_q [NUM_PHASES];
    logic [15:0] rdata_q;
    logic rvalid_q, invalid_q, refused_q;
    logic [8:0] delay_q;
    logic signed [23:0] rep_q, sum_q;

    function automatic logic [8:0] pictr_delay(input pictr_phase_s p);
        logic [8:0] d;
        d = '0;
        if (p.group_size != 4'h0)
            d = 9'((PICTR_PHASE_DEG_FULL / int'(p.group_size))
                * int'(p.position_index));
        return d;
    endfunction

    function automatic pictr_lin11_s pictr_to_lin(input logic signed [23:0] v,
                                                  input logic [4:0] e);
        pictr_lin11_s r;
        r.exponent = e;
        r.mantissa = v[10:0];
        return r;
    endfunction

    // Runtime decode of written words
    pictr_phase_s wr_phase;
    pictr_lin11_s wr_lin;
    logic signed [23:0] wr_gain, wr_offs, rs_gain, rs_offs;
    logic gain_lost, offs_lost, rgain_lost, roffs_lost;
    assign wr_phase = pictr_phase_s'(cmd_wdata);
    assign wr_lin = pictr_lin11_s'(cmd_wdata);

    pictr_lin11_norm #(.TARGET_EXP(-6)) u_gain_wr (
        .value(wr_lin), .scaled(wr_gain), .lost(gain_lost));
    pictr_lin11_norm #(.TARGET_EXP(-4)) u_offs_wr (
        .value(wr_lin), .scaled(wr_offs), .lost(offs_lost));
    pictr_lin11_norm #(.TARGET_EXP(-6)) u_gain_rs (
        .value(nvm_gain), .scaled(rs_gain), .lost(rgain_lost));
    pictr_lin11_norm #(.TARGET_EXP(-4)) u_offs_rs (
        .value(nvm_offset), .scaled(rs_offs), .lost(roffs_lost));

    wire sel_all = (phase_sel == PICTR_PHASE_ALL);
    wire sel_one = (phase_sel <= PICTR_PHASE_LAST)
        && (int'(phase_sel) < NUM_PHASES);
    wire [1:0] sel_idx = phase_sel[1:0];
    wire running = (state_q == PICTR_ST_RUN);
    wire wr_pp = running && cmd_wr && (cmd_code == PICTR_CMD_PHASE_POS);
    wire wr_gn = running && cmd_wr && (cmd_code == PICTR_CMD_GAIN_TRIM);
    wire wr_of = running && cmd_wr && (cmd_code == PICTR_CMD_OFFS_TRIM);
    wire pp_ok = (wr_phase.group_size >= PICTR_GSIZE_MIN)
        && (wr_phase.group_size <= PICTR_GSIZE_MAX)
        && (wr_phase.position_index < wr_phase.group_size);
    wire gn_ok = !gain_lost && (wr_gain >= 24'sd0)
        && (wr_gain <= 24'(signed'({1'b0, PICTR_GAIN_MAN_CAP})));
    wire signed [23:0] offs_split = wr_offs / 24'(signed'({1'b0, NPH}));
    wire of_ok = !offs_lost && (wr_offs >= OFFS_MIN)
        && (wr_offs <= OFFS_MAX) && (sel_all || sel_one);
    wire pp_take = wr_pp && !stack_locked_q && pp_ok;
    wire pp_refuse = wr_pp && stack_locked_q;
    wire bad_data = (wr_pp && !stack_locked_q && !pp_ok)
        || (wr_gn && !gn_ok) || (wr_of && !of_ok);

    // Restored gain rounded to 1/64 and capped; restored offset clamped to limits
    logic signed [23:0] rs_gain_cap;
    logic signed [23:0] rs_offs_cap;
    always_comb begin
        rs_gain_cap = rs_gain;
        if (rgain_lost || rs_gain > 24'(signed'({1'b0, PICTR_GAIN_MAN_CAP})))
            rs_gain_cap = 24'(signed'({1'b0, PICTR_GAIN_MAN_CAP}));
        else if (rs_gain < 24'sd0)
            rs_gain_cap = 24'sd0;
        rs_offs_cap = rs_offs;
        if (roffs_lost || rs_offs > OFFS_MAX)
            rs_offs_cap = OFFS_MAX;
        else if (rs_offs < OFFS_MIN)
            rs_offs_cap = OFFS_MIN;
    end

    // Read mux
    logic signed [23:0] offs_rd;
    logic [15:0] rd_word;
    logic signed [23:0] offs_total;
    always_comb begin
        offs_total = '0;
        for (int i = 0; i < NUM_PHASES; i++)
            offs_total = offs_total + offs_q[i];
        offs_rd = sel_all ? 24'(offs_q[0] * 24'(signed'({1'b0, NPH})))
            : offs_q[sel_idx];
        case (cmd_code)
            PICTR_CMD_PHASE_POS: rd_word = {4'h0, phase_q[11:0]};
            PICTR_CMD_GAIN_TRIM:
                rd_word = pictr_to_lin(gain_q, PICTR_GAIN_EXP_RST);
            PICTR_CMD_OFFS_TRIM:
                rd_word = pictr_to_lin(offs_rd, PICTR_OFFS_EXP_RST);
            default: rd_word = 16'h0000;
        endcase
    end

    // Reported current with gain in 1/64 units plus offset sum, registered one cycle later
    logic signed [39:0] prod;
    assign prod = 40'(sensed_current) * 40'(gain_q);
    wire signed [23:0] rep_d = 24'(prod >>> 6) + offs_total;

    always_comb begin
        state_d = state_q;
        case (state_q)
            PICTR_ST_BOOT: state_d = PICTR_ST_SAMPLE;
            PICTR_ST_SAMPLE: state_d = PICTR_ST_RUN;
            PICTR_ST_RUN: state_d = PICTR_ST_RUN;
            default: state_d = PICTR_ST_BOOT;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= PICTR_ST_BOOT;
            stack_locked_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (state_q == PICTR_ST_SAMPLE)
                stack_locked_q <= stack_config_multi;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= pictr_phase_s'(PICTR_PHASE_RST);
            gain_q <= 24'(signed'({1'b0, PICTR_GAIN_MAN_ONE}));
        end else if (state_q == PICTR_ST_BOOT || nvm_restore) begin
            phase_q <= {4'h0, nvm_phase_pos[11:0]};
            gain_q <= rs_gain_cap;
        end else begin
            if (pp_take)
                phase_q <= {4'h0, wr_phase[11:0]};
            if (wr_gn && gn_ok)
                gain_q <= wr_gain;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_PHASES; i++)
                offs_q[i] <= '0;
        end else if (state_q == PICTR_ST_BOOT || nvm_restore) begin
            for (int i = 0; i < NUM_PHASES; i++)
                offs_q[i] <= rs_offs_cap;
        end else if (wr_of && of_ok) begin
            for (int i = 0; i < NUM_PHASES; i++)
                if (sel_all)
                    offs_q[i] <= offs_split;
                else if (sel_idx == 2'(i))
                    offs_q[i] <= wr_offs;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            invalid_q <= 1'b0;
            refused_q <= 1'b0;
            delay_q <= 9'h000;
            rep_q <= '0;
            sum_q <= '0;
        end else begin
            rvalid_q <= cmd_rd && running;
            if (cmd_rd && running)
                rdata_q <= rd_word;
            invalid_q <= bad_data;
            refused_q <= pp_refuse;
            delay_q <= pictr_delay(phase_q);
            rep_q <= rep_d;
            sum_q <= offs_total;
        end
    end

    assign cmd_rdata = rdata_q;
    assign cmd_rvalid = rvalid_q;
    assign invalid_data = invalid_q;
    assign refused_write = refused_q;
    assign phase_delay_deg = delay_q;
    assign group_identifier = phase_q.group_identifier;
    assign reported_current = rep_q;
    assign stack_offset = sum_q;
endmodule
`default_nettype wire

// file: tb/pictr_host.sv
// Purpose: Management bus host model driving the command port
// Assumes: Caller lets RUN begin before the first command
// Notes: Idle data lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module pictr_host (
    input wire logic clk,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    output logic [7:0] phase_sel
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        phase_sel = 8'h00;
    end
    // Whole words only; strobes may stay high for back to back commands
    task automatic op(input logic w, input logic [7:0] c,
        input logic [15:0] d, input logic [7:0] p);
        @(posedge clk);
        #1;
        cmd_wr = w;
        cmd_rd = !w;
        cmd_code = c;
        cmd_wdata = d;
        phase_sel = p;
    endtask
    task automatic idle();
        @(posedge clk);
        #1;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule
`default_nettype wire

// file: tb/pictr_regs_checker.sv
// Purpose: Port checks for the trim register block
// Assumes: Reads answer one cycle after the strobe edge
// Notes: Phase checks wait out a write so the delay has settled
`timescale 1ns/1ps
`default_nettype none
module pictr_regs_checker
    import pictr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic invalid_data,
    input wire logic refused_write,
    input wire logic [8:0] phase_delay_deg,
    input wire logic [3:0] group_identifier
);
    logic [3:0] sz_w;
    logic [8:0] deg_w;
    assign sz_w = cmd_rdata[7:4];
    assign deg_w = (sz_w == 4'h0) ? 9'h000 :
        9'((PICTR_PHASE_DEG_FULL / int'(sz_w)) * int'(cmd_rdata[3:0]));
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rd_s(logic [7:0] c);
        cmd_rd && cmd_code == c ##1 cmd_rvalid;
    endsequence
    sequence quiet_rd_s;
        !cmd_wr ##1 !cmd_wr && cmd_rd && cmd_code == PICTR_CMD_PHASE_POS
        ##1 cmd_rvalid;
    endsequence
    rvalid_cause_a: assert property (cmd_rvalid |-> $past(cmd_rd))
        else $error("read data without a read strobe");
    refuse_cause_a: assert property (refused_write |->
        $past(cmd_wr) && $past(cmd_code) == PICTR_CMD_PHASE_POS)
        else $error("refusal without a phase position write");
    invalid_cause_a: assert property (invalid_data |-> $past(cmd_wr))
        else $error("invalid flag without a write");
    phase_top_a: assert property (rd_s(PICTR_CMD_PHASE_POS) |->
        cmd_rdata[15:12] == 4'h0)
        else $error("phase position top bits not zero");
    phase_deg_a: assert property (quiet_rd_s |->
        phase_delay_deg == deg_w)
        else $error("phase delay does not match size and index");
    grp_id_a: assert property (quiet_rd_s |->
        group_identifier == cmd_rdata[11:8])
        else $error("group identifier output differs from register");
    gain_exp_a: assert property (rd_s(PICTR_CMD_GAIN_TRIM) |->
        cmd_rdata[15:11] == PICTR_GAIN_EXP_RST)
        else $error("gain read exponent wrong");
    gain_cap_a: assert property (rd_s(PICTR_CMD_GAIN_TRIM) |->
        cmd_rdata[10:0] <= PICTR_GAIN_MAN_CAP)
        else $error("gain above cap");
    offs_exp_a: assert property (rd_s(PICTR_CMD_OFFS_TRIM) |->
        cmd_rdata[15:11] == PICTR_OFFS_EXP_RST)
        else $error("offset read exponent wrong");
endmodule
bind pictr_regs pictr_regs_checker u_chk (.clk(clk), .reset_n(reset_n),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .invalid_data(invalid_data), .refused_write(refused_write),
    .phase_delay_deg(phase_delay_deg), .group_identifier(group_identifier));
`default_nettype wire

// file: tb/pictr_regs_tb.sv
// Purpose: Self-checking bench for the trim register block
// Assumes: Design defaults for phase count and offset limits
// Notes: Flags and read data are matched against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module pictr_regs_tb;
    import pictr_pkg::*;
    logic clk, reset_n, stack_config_multi, nvm_restore;
    logic cmd_wr, cmd_rd, cmd_rvalid, invalid_data, refused_write;
    logic [7:0] cmd_code, phase_sel;
    logic [15:0] cmd_wdata, cmd_rdata, d;
    pictr_lin11_s nvm_gain, nvm_offset;
    pictr_phase_s nvm_phase_pos;
    logic signed [15:0] sensed_current;
    logic [8:0] phase_delay_deg;
    logic [3:0] group_identifier;
    logic signed [23:0] reported_current, stack_offset;
    logic [17:0] exp_q[$];
    // Size zero, size five, index equal to size, index past size
    logic [15:0] pp_bad [4] = '{16'h0000, 16'h0050, 16'h0022, 16'h0F45};
    logic [15:0] offs_set [4] = '{16'hE010, 16'hE020, 16'hE7F8, 16'hE008};
    int err_total, n_compared;
    integer seed;
    pictr_host u_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .phase_sel(phase_sel));
    pictr_regs u_dut (.clk(clk), .reset_n(reset_n), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .phase_sel(phase_sel), .stack_config_multi(stack_config_multi),
        .nvm_restore(nvm_restore), .nvm_gain(nvm_gain),
        .nvm_offset(nvm_offset), .nvm_phase_pos(nvm_phase_pos),
        .sensed_current(sensed_current), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .invalid_data(invalid_data),
        .refused_write(refused_write), .phase_delay_deg(phase_delay_deg),
        .group_identifier(group_identifier),
        .reported_current(reported_current), .stack_offset(stack_offset));
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (exp_q.size() != 0) err_total++;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Accepted writes leave no note; only reads, refusals and invalid writes answer
    task automatic wr(input logic [7:0] c, input logic [15:0] v,
        input logic [7:0] p = 8'h00, input logic [1:0] f = 2'b00);
        u_host.op(1'b1, c, v, p);
        if (f != 2'b00) exp_q.push_back({f, 16'h0000});
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] v,
        input logic [7:0] p = 8'h00);
        u_host.op(1'b0, c, 16'h0000, p);
        exp_q.push_back({2'b00, v});
    endtask
    task automatic settle();
        u_host.idle();
        repeat (3) @(posedge clk);
        #2;
    endtask
    task automatic do_reset(input logic multi);
        reset_n = 1'b0;
        stack_config_multi = multi;
        repeat (20) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk) begin
        #2;
        if ((cmd_rvalid | invalid_data | refused_write) !== 1'b0) begin
            if (exp_q.size() == 0) begin
                check(24'h0, 24'hFFFFFF);
            end else begin
                check({6'h0, invalid_data, refused_write,
                    cmd_rvalid ? cmd_rdata : 16'h0000}, {6'h0, exp_q.pop_front()});
            end
        end
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end
    initial begin
        seed = 32'h2A3B;
        nvm_restore = 1'b0;
        nvm_gain = 16'hC105;
        nvm_offset = 16'hE028;
        nvm_phase_pos = 16'h0342;
        sensed_current = 16'sh0000;
        do_reset(1'b0);
        rd(PICTR_CMD_PHASE_POS, 16'h0342);
        rd(PICTR_CMD_GAIN_TRIM, 16'hD041);
        rd(PICTR_CMD_OFFS_TRIM, 16'hE028);
        rd(8'h40, 16'h0000);
        wr(PICTR_CMD_PHASE_POS, 16'hA130);
        rd(PICTR_CMD_PHASE_POS, 16'h0130);
        foreach (pp_bad[k]) begin
            wr(PICTR_CMD_PHASE_POS, pp_bad[k], 8'h00, 2'b10);
        end
        rd(PICTR_CMD_PHASE_POS, 16'h0130);
        for (int s = 1; s <= 4; s++) begin
            for (int i = 0; i < s; i++) begin
                d = {4'h0, 4'($random(seed)), 4'(s), 4'(i)};
                wr(PICTR_CMD_PHASE_POS, d);
                u_host.idle();
                rd(PICTR_CMD_PHASE_POS, d);
            end
        end
        wr(PICTR_CMD_GAIN_TRIM, 16'hD040);
        wr(PICTR_CMD_GAIN_TRIM, 16'hD080, 8'h00, 2'b10);
        rd(PICTR_CMD_GAIN_TRIM, 16'hD040);
        wr(PICTR_CMD_OFFS_TRIM, 16'hE000, PICTR_PHASE_ALL);
        sensed_current = 16'($random(seed) % 1000);
        settle();
        check(reported_current, 24'(sensed_current));
        wr(PICTR_CMD_GAIN_TRIM, 16'hD060);
        sensed_current = 16'sd100;
        settle();
        check(reported_current, 24'd150);
        foreach (offs_set[p]) begin
            wr(PICTR_CMD_OFFS_TRIM, offs_set[p], 8'(p));
        end
        settle();
        check(stack_offset, 24'd48);
        rd(PICTR_CMD_OFFS_TRIM, 16'hE7F8, 8'h02);
        wr(PICTR_CMD_OFFS_TRIM, 16'hE028, PICTR_PHASE_ALL);
        rd(PICTR_CMD_OFFS_TRIM, 16'hE028, PICTR_PHASE_ALL);
        rd(PICTR_CMD_OFFS_TRIM, 16'hE00A, 8'h01);
        wr(PICTR_CMD_OFFS_TRIM, 16'h0064, 8'h00, 2'b10);
        wr(PICTR_CMD_OFFS_TRIM, 16'hE008, 8'h05, 2'b10);
        settle();
        check(stack_offset, 24'd40);
        @(posedge clk);
        #1;
        nvm_gain = 16'hD0A0;
        nvm_restore = 1'b1;
        @(posedge clk);
        #1;
        nvm_restore = 1'b0;
        settle();
        check(stack_offset, 24'd160);
        rd(PICTR_CMD_GAIN_TRIM, 16'hD07F);
        settle();
        do_reset(1'b1);
        wr(PICTR_CMD_PHASE_POS, 16'h0110, 8'h00, 2'b01);
        rd(PICTR_CMD_PHASE_POS, 16'h0342);
        stack_config_multi = 1'b0;
        wr(PICTR_CMD_PHASE_POS, 16'h0110, 8'h00, 2'b01);
        rd(PICTR_CMD_PHASE_POS, 16'h0342);
        settle();
        complete_run();
    end
endmodule
`default_nettype wire
